// ---- inc/pdt_pkg.sv ----
// register map, field positions and timing constants for the pwm unit
package pdt_pkg;
  localparam int unsigned ADDR_W = 6;
  // byte offsets of the registers
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_PERIOD = 6'h04;
  localparam logic [5:0] OFS_COMPARE = 6'h08;
  localparam logic [5:0] OFS_RISE = 6'h0c;
  localparam logic [5:0] OFS_FALL = 6'h10;
  localparam logic [5:0] OFS_BSTART = 6'h14;
  localparam logic [5:0] OFS_BWIDTH = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1c;
  localparam logic [5:0] OFS_COUNT = 6'h20;
  // control field positions
  localparam int unsigned CTL_RUN = 0;
  localparam int unsigned CTL_RSHADOW = 1;
  localparam int unsigned CTL_FSHADOW = 2;
  localparam int unsigned CTL_TRIPEN = 3;
  localparam int unsigned CTL_SOCEN = 4;
  localparam int unsigned CTL_BLANKEN = 5;
  localparam int unsigned CTL_W = 6;
  // status field positions
  localparam int unsigned STS_TRIP = 0;
  localparam int unsigned STS_BLANK = 1;
  localparam int unsigned STS_HALT = 2;
  // reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  // cycles at window start during which trips still pass
  localparam logic [1:0] BLANK_LAG = 2'h3;
endpackage

// ---- core/pdt_pwm.sv ----
// pwm unit with dead-band, trip blanking and avalon-mm registers
module pdt_pwm
  import pdt_pkg::*;
#(
  parameter bit UNIT_IS_SEVEN = 1'b0,
  parameter int unsigned CNT_W = 16,
  parameter int unsigned DB_W = 10
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic core_idle,
  input wire logic debug_halt,
  input wire logic raw_compare_event,
  output logic pwm_a,
  output logic pwm_b,
  output logic filtered_compare_event,
  output logic converter_start
);
  logic [2:0] sync1_reg, sync2_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [CTL_W-1:0] ctrl_reg;
  logic [CNT_W-1:0] period_reg, compare_reg, count_reg;
  logic [CNT_W-1:0] bstart_reg, bwidth_reg, bcnt_reg;
  logic [1:0] age_reg;
  logic [DB_W-1:0] rise_sh_reg, fall_sh_reg, rise_act_reg, fall_act_reg;
  logic [DB_W-1:0] rise_cnt_reg, fall_cnt_reg;
  logic trip_reg, filt_prev_reg, soc_reg, pa_reg, pb_reg;

  // two-flop synchronisers for the pins
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= {raw_compare_event, debug_halt, core_idle};
      sync2_reg <= sync1_reg;
    end
  end

  // bus decode: one wait cycle, writes take effect at ack, reads sample the mux in the wait cycle
  wire req = avs_read | avs_write;
  wire wr_go = avs_write & ack_reg;
  wire wr_ctrl = wr_go & (avs_address == OFS_CTRL);
  wire wr_period = wr_go & (avs_address == OFS_PERIOD);
  wire wr_compare = wr_go & (avs_address == OFS_COMPARE);
  wire wr_rise = wr_go & (avs_address == OFS_RISE);
  wire wr_fall = wr_go & (avs_address == OFS_FALL);
  wire wr_bstart = wr_go & (avs_address == OFS_BSTART);
  wire wr_bwidth = wr_go & (avs_address == OFS_BWIDTH);
  wire wr_status = wr_go & (avs_address == OFS_STATUS);
  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata = rdata_reg;

  // core clock gate: seventh unit stops on idle or halt
  wire core_stopped = sync2_reg[0] | sync2_reg[1];
  wire halted = UNIT_IS_SEVEN & core_stopped;
  wire run = ctrl_reg[CTL_RUN] & ~halted;
  wire wrap = run & (count_reg >= period_reg);
  wire load_evt = wrap; // counter returns to zero
  wire raw_pwm = count_reg < compare_reg;

  // blanking window and trip filtering
  wire blank_start = run & ctrl_reg[CTL_BLANKEN] & (count_reg == bstart_reg);
  wire blank_open = bcnt_reg != '0;
  wire mask = blank_open & (age_reg == BLANK_LAG);
  wire raw_evt = sync2_reg[2];
  wire filt = raw_evt & ~mask;
  wire trip_set = filt & ctrl_reg[CTL_TRIPEN];
  wire trip_clr = wr_status & avs_writedata[STS_TRIP];

  // read mux
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0;
    case (avs_address)
      OFS_CTRL: rmux = 32'(ctrl_reg);
      OFS_PERIOD: rmux = 32'(period_reg);
      OFS_COMPARE: rmux = 32'(compare_reg);
      OFS_RISE: rmux = 32'(rise_sh_reg);
      OFS_FALL: rmux = 32'(fall_sh_reg);
      OFS_BSTART: rmux = 32'(bstart_reg);
      OFS_BWIDTH: rmux = 32'(bwidth_reg);
      OFS_STATUS: rmux = 32'({halted, blank_open, trip_reg});
      OFS_COUNT: rmux = 32'(count_reg);
      default: rmux = 32'h0;
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= req & ~ack_reg;
      if (avs_read & ~ack_reg)
        rdata_reg <= rmux;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RST;
      period_reg <= PERIOD_RST;
      compare_reg <= '0;
      bstart_reg <= '0;
      bwidth_reg <= '0;
      rise_sh_reg <= '0;
      fall_sh_reg <= '0;
    end
    else
    begin
      if (wr_ctrl) ctrl_reg <= avs_writedata[CTL_W-1:0];
      if (wr_period) period_reg <= avs_writedata[CNT_W-1:0];
      if (wr_compare) compare_reg <= avs_writedata[CNT_W-1:0];
      if (wr_bstart) bstart_reg <= avs_writedata[CNT_W-1:0];
      if (wr_bwidth) bwidth_reg <= avs_writedata[CNT_W-1:0];
      if (wr_rise) rise_sh_reg <= avs_writedata[DB_W-1:0];
      if (wr_fall) fall_sh_reg <= avs_writedata[DB_W-1:0];
    end
  end

  // active delays: immediate on write, shadow at load event
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rise_act_reg <= '0;
      fall_act_reg <= '0;
    end
    else
    begin
      if (wr_rise & ~ctrl_reg[CTL_RSHADOW])
        rise_act_reg <= avs_writedata[DB_W-1:0];
      else if (load_evt & ctrl_reg[CTL_RSHADOW])
        rise_act_reg <= rise_sh_reg;
      if (wr_fall & ~ctrl_reg[CTL_FSHADOW])
        fall_act_reg <= avs_writedata[DB_W-1:0];
      else if (load_evt & ctrl_reg[CTL_FSHADOW])
        fall_act_reg <= fall_sh_reg;
    end
  end

  // counter, window, dead-band counters; all frozen when not running
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      count_reg <= '0;
      bcnt_reg <= '0;
      age_reg <= 2'h0;
      rise_cnt_reg <= '0;
      fall_cnt_reg <= '0;
    end
    else if (run)
    begin
      count_reg <= wrap ? '0 : count_reg + 1'b1;
      if (blank_start)
      begin
        bcnt_reg <= bwidth_reg;
        age_reg <= 2'h0;
      end
      else if (blank_open)
      begin
        bcnt_reg <= bcnt_reg - 1'b1;
        if (age_reg != BLANK_LAG) age_reg <= age_reg + 1'b1;
      end
      rise_cnt_reg <= !raw_pwm ? '0 :
        (rise_cnt_reg < rise_act_reg) ? rise_cnt_reg + 1'b1 : rise_cnt_reg;
      fall_cnt_reg <= raw_pwm ? '0 :
        (fall_cnt_reg < fall_act_reg) ? fall_cnt_reg + 1'b1 : fall_cnt_reg;
    end
  end

  // outputs, trip flag and converter trigger
  wire pa_next = raw_pwm & (rise_cnt_reg >= rise_act_reg) & ~trip_reg;
  wire pb_next = ~raw_pwm & (fall_cnt_reg >= fall_act_reg) & ~trip_reg;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      trip_reg <= 1'b0;
      filt_prev_reg <= 1'b0;
      soc_reg <= 1'b0;
      pa_reg <= 1'b0;
      pb_reg <= 1'b0;
    end
    else
    begin
      trip_reg <= trip_set | (trip_reg & ~trip_clr);
      filt_prev_reg <= filt;
      soc_reg <= filt & ~filt_prev_reg & ctrl_reg[CTL_SOCEN];
      pa_reg <= run & pa_next & ~trip_set;
      pb_reg <= run & pb_next & ~trip_set;
    end
  end
  assign pwm_a = pa_reg;
  assign pwm_b = pb_reg;
  assign filtered_compare_event = filt;
  assign converter_start = soc_reg;

  // checks, all on the system clock
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a window long enough to reach its masking phase
  sequence s_window_begins;
    blank_start && (bwidth_reg > BLANK_LAG);
  endsequence
  // lag cycles with the unit running and no restart
  sequence s_lag_running;
    (run && !blank_start)[*3];
  endsequence
  a_halt_freezes_count:
    assert property (halted |=> $stable(count_reg))
    else $error("counter moved while halted");
  a_idle_halts_seven:
    assert property ((UNIT_IS_SEVEN && core_stopped)
      |=> ($stable(count_reg) && !pwm_a && !pwm_b))
    else $error("seventh unit not halted");
  a_others_keep_running:
    assert property ((!UNIT_IS_SEVEN && ctrl_reg[CTL_RUN])
      |=> (count_reg != $past(count_reg) || count_reg == '0))
    else $error("unit halted");
  a_zero_delay_direct:
    assert property ((run && rise_act_reg == '0 && raw_pwm && !trip_reg
      && !trip_set) |=> pwm_a)
    else $error("zero delay not applied");
  a_mask_blocks_trip:
    assert property (mask |-> !filtered_compare_event)
    else $error("trip passed window");
  a_first_cycles_pass:
    assert property (s_window_begins |=> !mask ##1 !mask ##1 !mask)
    else $error("window masked too early");
  a_mask_after_lag:
    assert property (s_window_begins ##1 s_lag_running |=> mask)
    else $error("window never masks");
  a_trip_latches:
    assert property (trip_set |=> trip_reg ##1 (!pwm_a && !pwm_b))
    else $error("trip not latched");
  a_window_spans_wrap:
    assert property ((wrap && bcnt_reg > 1 && !blank_start) |=> blank_open)
    else $error("window cut at wrap");
  a_shadow_holds:
    assert property ((ctrl_reg[CTL_RSHADOW] && !load_evt)
      |=> $stable(rise_act_reg))
    else $error("shadow loaded early");
endmodule

// ---- sim/pdt_gate_model.sv ----
// gate driver model that flags both switches of one leg on at once
module pdt_gate_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pwm_a,
  input wire logic pwm_b,
  output int overlap_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // shoot-through count, a real bridge would short the rail here
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      overlap_cnt <= 0;
    else if (pwm_a === 1'b1 && pwm_b === 1'b1)
      overlap_cnt <= overlap_cnt + 1;
  end
endmodule

// ---- sim/pdt_pwm_tb_top.sv ----
// bench for the pwm unit: bus, dead-band, trip, blanking and halt
`define CHK(g, e) \
  begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module pdt_pwm_tb_top;
  import pdt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, avs_read, avs_write, core_idle, debug_halt, raw;
  logic avs_waitrequest, pwm_a, pwm_b, filt, conv;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [31:0] avs_readdata_other, rd_other;
  int err_total, checks, overlap_cnt, k;
  pdt_pwm #(.UNIT_IS_SEVEN(1'b1)) pdt_pwm_inst (.clk_sys(clk_sys),
    .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_idle(core_idle), .debug_halt(debug_halt),
    .raw_compare_event(raw), .pwm_a(pwm_a), .pwm_b(pwm_b),
    .filtered_compare_event(filt), .converter_start(conv));
  pdt_gate_model pdt_gate_model_inst (.clk_sys(clk_sys), .rst(rst),
    .pwm_a(pwm_a), .pwm_b(pwm_b), .overlap_cnt(overlap_cnt));
  // system-clock unit on the same bus, must keep running through halt
  pdt_pwm #(.UNIT_IS_SEVEN(1'b0)) pdt_pwm_other_inst (.clk_sys(clk_sys),
    .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata_other), .avs_waitrequest(),
    .core_idle(core_idle), .debug_halt(debug_halt),
    .raw_compare_event(raw), .pwm_a(), .pwm_b(),
    .filtered_compare_event(), .converter_start());
  // free-running 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // one avalon transfer, held until a rising edge sees waitrequest low
  task automatic bus(input logic wr, input logic [5:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    rd_other = avs_readdata_other;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // reset values and an unmapped address
  task automatic t_regs();
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[5:0], CTRL_RST)
    bus(1'b0, OFS_PERIOD, 32'h0);
    `CHK(rd[15:0], PERIOD_RST)
    bus(1'b1, 6'h24, 32'hffffffff);
    bus(1'b0, 6'h24, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  // zero delays loaded at once give a clean complementary pair
  task automatic t_zero();
    bus(1'b1, OFS_PERIOD, 32'h0f);
    bus(1'b1, OFS_COMPARE, 32'h08);
    bus(1'b1, OFS_RISE, 32'h0);
    bus(1'b1, OFS_FALL, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h01);
    repeat (20) @(posedge clk_sys);
    repeat (32)
    begin
      @(negedge clk_sys);
      `CHK(pwm_a ^ pwm_b, 1'b1)
    end
  endtask
  // shadowed rising delay opens a dead gap after the wrap
  task automatic t_shadow();
    bus(1'b1, OFS_CTRL, 32'h03);
    bus(1'b1, OFS_RISE, 32'h04);
    bus(1'b0, OFS_RISE, 32'h0);
    `CHK(rd[9:0], 10'h004)
    repeat (40) @(posedge clk_sys);
    k = 0;
    repeat (16)
    begin
      @(negedge clk_sys);
      if (pwm_a === 1'b0 && pwm_b === 1'b0)
        k++;
    end
    `CHK(k, 4)
    `CHK(overlap_cnt, 0)
    bus(1'b1, OFS_CTRL, 32'h01);
  endtask
  // unblanked trip reaches flag, start pulse and outputs
  task automatic t_trip();
    bus(1'b1, OFS_CTRL, 32'h19);
    raw <= 1'b1;
    k = 0;
    repeat (8)
    begin
      @(negedge clk_sys);
      if (conv === 1'b1)
        k++;
    end
    `CHK(filt, 1'b1)
    `CHK(k, 1)
    `CHK({pwm_a, pwm_b}, 2'b00)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[STS_TRIP], 1'b1)
    raw <= 1'b0;
    repeat (4) @(posedge clk_sys);
    bus(1'b1, OFS_STATUS, 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[STS_TRIP], 1'b0)
  endtask
  // window across the wrap masks all but its first cycles
  task automatic t_blank();
    bus(1'b1, OFS_BSTART, 32'h0e);
    bus(1'b1, OFS_BWIDTH, 32'h08);
    bus(1'b1, OFS_CTRL, 32'h21);
    raw <= 1'b1;
    repeat (40) @(posedge clk_sys);
    k = 0;
    repeat (16)
    begin
      @(negedge clk_sys);
      if (filt === 1'b0)
        k++;
    end
    `CHK(k, 8 - int'(BLANK_LAG))
    @(posedge clk_sys);
    raw <= 1'b0;
  endtask
  // idle and debug halt both freeze this unit
  task automatic t_halt();
    logic [31:0] c0;
    logic [31:0] c2;
    for (int i = 0; i < 2; i++)
    begin
      {debug_halt, core_idle} <= 2'b01 << i;
      repeat (6) @(posedge clk_sys);
      bus(1'b0, OFS_COUNT, 32'h0);
      c0 = rd;
      c2 = rd_other;
      bus(1'b0, OFS_COUNT, 32'h0);
      `CHK(rd, c0)
      `CHK(rd_other !== c2, 1'b1)
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[STS_HALT], 1'b1)
      `CHK(rd_other[STS_HALT], 1'b0)
      `CHK({pwm_a, pwm_b}, 2'b00)
      {debug_halt, core_idle} <= 2'b00;
      repeat (6) @(posedge clk_sys);
      bus(1'b0, OFS_COUNT, 32'h0);
      `CHK(rd !== c0, 1'b1)
    end
  endtask
  // counts and verdict, the single end of the run
  task automatic results();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    core_idle = 1'b0;
    debug_halt = 1'b0;
    raw = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_zero();
    t_shadow();
    t_trip();
    t_blank();
    t_halt();
    results();
  end
  // watchdog against a hung handshake
  initial
  begin
    #200us;
    err_total++;
    results();
  end
endmodule
